// ### shared/acsr_pkg.sv
// Constants for the converter control and status register block
// How it works
// - Busy flag reads 1 while converting, 0 once the conversion completed.
// - Power-off bit 0 keeps converter powered; 1 switches it off.
// - Justify bit 0 puts result MSB..LSB at high7..low4; 1 at high3..low0.
// - With internal reference off, channel field picks external input 0..3.
// - Start 0 to 1 resets converter, sets busy; 1 to 0 begins conversion.
// - Internal reference select routes bandgap, disconnects all external inputs.
// - Result bits not holding the 12-bit value read as zero.
package acsr_pkg;
    localparam int RES_W = 12;
    localparam int DATA_W = 32;
    localparam int IDX_W = 3;
    localparam int EVT_W = 2;
    // Register word indexes, byte address is four times these
    localparam logic [IDX_W-1:0] IDX_CTRL0 = 3'h0;
    localparam logic [IDX_W-1:0] IDX_CTRL1 = 3'h1;
    localparam logic [IDX_W-1:0] IDX_RES_HI = 3'h2;
    localparam logic [IDX_W-1:0] IDX_RES_LO = 3'h3;
    localparam logic [IDX_W-1:0] IDX_STATUS = 3'h4;
    localparam logic [IDX_W-1:0] IDX_MASK = 3'h5;
    // First control register fields
    localparam int C0_START = 7;
    localparam int C0_BUSY = 6;
    localparam int C0_OFF = 5;
    localparam int C0_JUST = 4;
    localparam int C0_CH1 = 1;
    localparam int C0_CH0 = 0;
    // Second control register fields
    localparam int C1_INTREF = 7;
    localparam int C1_BGEN = 6;
    localparam int C1_VREF = 4;
    localparam int C1_DIV2 = 2;
    localparam int C1_DIV0 = 0;
    // Event bits
    localparam int EV_DONE = 0;
    localparam int EV_START_OFF = 1;
    // Reset values
    localparam logic RST_START = 1'b0;
    localparam logic RST_BUSY = 1'b1;
    localparam logic RST_OFF = 1'b1;
    localparam logic RST_JUST = 1'b0;
    localparam logic [1:0] RST_CHAN = 2'h0;
    localparam logic [7:0] RST_CTRL1 = 8'h00;
    localparam logic [EVT_W-1:0] RST_EVT = 2'h0;
endpackage

// ### rtl/acsr_result_fmt.sv
// Places the conversion value into the two result bytes
module acsr_result_fmt (
    // Value and format
    input wire logic [acsr_pkg::RES_W-1:0] result,
    input wire logic justify_right,
    // Result bytes
    output logic [7:0] result_high_byte,
    output logic [7:0] result_low_byte
);
    logic [15:0] packed_w;

    always_comb
    begin
        // Unused positions are filled with zero either way
        if (justify_right)
        begin
            packed_w = {4'h0, result};
        end
        else
        begin
            packed_w = {result, 4'h0};
        end
        result_high_byte = packed_w[15:8];
        result_low_byte = packed_w[7:0];
    end
endmodule

// ### rtl/acsr_chan_route.sv
// Decodes the analog input routing from the channel controls
module acsr_chan_route (
    // Controls
    input wire logic [1:0] chan,
    input wire logic internal_ref_select,
    // Routing
    output logic [3:0] analog_input_sel,
    output logic bandgap_route
);
    always_comb
    begin
        analog_input_sel = 4'h0;
        bandgap_route = internal_ref_select;
        if (!internal_ref_select)
        begin
            analog_input_sel[chan] = 1'b1;
        end
    end
endmodule

// ### rtl/acsr_top.sv
// Converter control and status registers behind an AHB-Lite slave
module acsr_top (
    // Clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // AHB-Lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    // Converter side
    input wire logic conv_done,
    input wire logic [acsr_pkg::RES_W-1:0] conv_data,
    output logic conv_reset,
    output logic conv_start,
    output logic converter_power_off,
    output logic bandgap_enable,
    output logic reference_source_select,
    output logic [2:0] conv_clock_div,
    output logic [3:0] analog_input_sel,
    output logic bandgap_route,
    // Interrupt
    output logic irq
);
    typedef struct packed {
        logic start;
        logic busy;
        logic power_off;
        logic justify;
        logic [1:0] chan;
        logic int_ref;
        logic bg_en;
        logic vref_sel;
        logic [2:0] clk_div;
        logic [acsr_pkg::RES_W-1:0] result;
        logic [acsr_pkg::EVT_W-1:0] status;
        logic [acsr_pkg::EVT_W-1:0] mask;
        logic wr_pend;
        logic [acsr_pkg::IDX_W-1:0] wr_idx;
        logic conv_start;
        logic [31:0] rdata;
    } acsr_state_t;

    acsr_state_t q;
    acsr_state_t d;
    logic [7:0] res_hi;
    logic [7:0] res_lo;
    logic addr_ok;
    logic req;
    logic rd_req;
    logic rd_stall;
    logic [acsr_pkg::IDX_W-1:0] a_idx;
    logic [acsr_pkg::EVT_W-1:0] events;
    logic [7:0] rd_byte;
    logic [7:0] ctrl1_w;

    acsr_result_fmt u_fmt (
        .result(q.result),
        .justify_right(q.justify),
        .result_high_byte(res_hi),
        .result_low_byte(res_lo)
    );

    acsr_chan_route u_route (
        .chan(q.chan),
        .internal_ref_select(q.int_ref),
        .analog_input_sel(analog_input_sel),
        .bandgap_route(bandgap_route)
    );

    // Upper address bits beyond the window are not decoded
    assign a_idx = haddr[acsr_pkg::IDX_W+1:2];
    assign addr_ok = (haddr[7:acsr_pkg::IDX_W+2] == 3'h0);
    assign req = hsel && htrans[1] && hready;
    assign rd_req = req && !hwrite;
    // A read right behind a write waits one cycle so it sees the new value
    assign rd_stall = rd_req && q.wr_pend;
    assign ctrl1_w = hwdata[7:0];

    always_comb
    begin
        d = q;
        d.conv_start = 1'b0;
        events = '0;
        rd_byte = 8'h00;
        // Completion is ignored while the converter is held in reset
        if (conv_done && !q.start && q.busy)
        begin
            d.result = conv_data;
            d.busy = 1'b0;
            events[acsr_pkg::EV_DONE] = 1'b1;
        end
        if (q.wr_pend)
        begin
            unique case (q.wr_idx)
                acsr_pkg::IDX_CTRL0:
                begin
                    d.start = hwdata[acsr_pkg::C0_START];
                    d.power_off = hwdata[acsr_pkg::C0_OFF];
                    d.justify = hwdata[acsr_pkg::C0_JUST];
                    d.chan = hwdata[acsr_pkg::C0_CH1:acsr_pkg::C0_CH0];
                    // Bits 3..2 and the busy bit are not stored
                    if (hwdata[acsr_pkg::C0_START] && !q.start)
                    begin
                        d.busy = 1'b1;
                        events[acsr_pkg::EV_START_OFF] =
                            hwdata[acsr_pkg::C0_OFF];
                    end
                    if (!hwdata[acsr_pkg::C0_START] && q.start)
                    begin
                        d.conv_start = 1'b1;
                    end
                end
                acsr_pkg::IDX_CTRL1:
                begin
                    d.int_ref = ctrl1_w[acsr_pkg::C1_INTREF];
                    d.bg_en = ctrl1_w[acsr_pkg::C1_BGEN];
                    d.vref_sel = ctrl1_w[acsr_pkg::C1_VREF];
                    d.clk_div = ctrl1_w[acsr_pkg::C1_DIV2:acsr_pkg::C1_DIV0];
                end
                acsr_pkg::IDX_STATUS:
                begin
                    d.status = q.status & ~hwdata[acsr_pkg::EVT_W-1:0];
                end
                acsr_pkg::IDX_MASK:
                begin
                    d.mask = hwdata[acsr_pkg::EVT_W-1:0];
                end
                default:
                begin
                end
            endcase
        end
        // A new event wins over a clear in the same cycle
        d.status = d.status | events;
        d.wr_pend = req && hwrite && addr_ok;
        d.wr_idx = a_idx;
        if (rd_req && !rd_stall)
        begin
            if (addr_ok)
            begin
                unique case (a_idx)
                    acsr_pkg::IDX_CTRL0:
                    begin
                        rd_byte = {q.start, q.busy, q.power_off, q.justify,
                                   2'h0, q.chan};
                    end
                    acsr_pkg::IDX_CTRL1:
                    begin
                        rd_byte = {q.int_ref, q.bg_en, 1'b0, q.vref_sel,
                                   1'b0, q.clk_div};
                    end
                    acsr_pkg::IDX_RES_HI:
                    begin
                        rd_byte = res_hi;
                    end
                    acsr_pkg::IDX_RES_LO:
                    begin
                        rd_byte = res_lo;
                    end
                    acsr_pkg::IDX_STATUS:
                    begin
                        rd_byte = {6'h00, q.status};
                    end
                    acsr_pkg::IDX_MASK:
                    begin
                        rd_byte = {6'h00, q.mask};
                    end
                    default:
                    begin
                        rd_byte = 8'h00;
                    end
                endcase
            end
            d.rdata = {24'h000000, rd_byte};
        end
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            q.start <= acsr_pkg::RST_START;
            q.busy <= acsr_pkg::RST_BUSY;
            q.power_off <= acsr_pkg::RST_OFF;
            q.justify <= acsr_pkg::RST_JUST;
            q.chan <= acsr_pkg::RST_CHAN;
            q.int_ref <= acsr_pkg::RST_CTRL1[acsr_pkg::C1_INTREF];
            q.bg_en <= acsr_pkg::RST_CTRL1[acsr_pkg::C1_BGEN];
            q.vref_sel <= acsr_pkg::RST_CTRL1[acsr_pkg::C1_VREF];
            q.clk_div <= acsr_pkg::RST_CTRL1[acsr_pkg::C1_DIV2:0];
            q.result <= '0;
            q.status <= acsr_pkg::RST_EVT;
            q.mask <= acsr_pkg::RST_EVT;
            q.wr_pend <= 1'b0;
            q.wr_idx <= '0;
            q.conv_start <= 1'b0;
            q.rdata <= 32'h00000000;
        end
        else
        begin
            q <= d;
        end
    end

    assign hreadyout = !rd_stall;
    assign hresp = 1'b0;
    assign hrdata = q.rdata;
    assign conv_reset = q.start;
    assign conv_start = q.conv_start;
    assign converter_power_off = q.power_off;
    assign bandgap_enable = q.bg_en;
    assign reference_source_select = q.vref_sel;
    assign conv_clock_div = q.clk_div;
    assign irq = |(q.status & q.mask);

    default clocking cb @(posedge hclk);
    endclocking
    default disable iff (!hresetn);

    AST_START_SETS_BUSY: assert property (
        q.wr_pend && q.wr_idx == acsr_pkg::IDX_CTRL0 && !q.start
        && hwdata[acsr_pkg::C0_START] |=> q.busy && conv_reset)
        else $error("busy not set on start rise");

    AST_START_FALL_PULSE: assert property (
        $fell(q.start) |-> conv_start ##1 !conv_start)
        else $error("no single start pulse on start fall");

    AST_DONE_CLEARS_BUSY: assert property (
        conv_done && q.busy && !q.start && !q.wr_pend
        |=> !q.busy && q.result == $past(conv_data)
        && q.status[acsr_pkg::EV_DONE])
        else $error("completion did not clear busy");

    AST_POWER_ON_WRITE: assert property (
        q.wr_pend && q.wr_idx == acsr_pkg::IDX_CTRL0
        && !hwdata[acsr_pkg::C0_OFF] |=> !converter_power_off)
        else $error("power-off not cleared by write");

    AST_LEFT_JUSTIFY: assert property (
        !q.justify |-> {res_hi, res_lo} == {q.result, 4'h0})
        else $error("left justified placement wrong");

    AST_RIGHT_JUSTIFY: assert property (
        q.justify |-> res_hi[7:4] == 4'h0
        && {res_hi[3:0], res_lo} == q.result)
        else $error("right justified placement wrong");

    AST_EXT_CHANNEL: assert property (
        !q.int_ref |-> analog_input_sel == (4'h1 << q.chan)
        && !bandgap_route)
        else $error("external channel routing wrong");

    AST_INTERNAL_REF: assert property (
        q.int_ref |-> analog_input_sel == 4'h0 && bandgap_route)
        else $error("bandgap routing wrong");

    AST_CTRL0_UNUSED_ZERO: assert property (
        rd_req && !rd_stall && addr_ok && a_idx == acsr_pkg::IDX_CTRL0
        |=> hrdata[3:2] == 2'h0 && hrdata[6] == $past(q.busy))
        else $error("control read returned wrong reserved or busy bits");

    // Busy only drops on a completion the converter may report
    AST_BUSY_HOLDS: assert property (
        q.busy && !(conv_done && !q.start) |=> q.busy)
        else $error("busy dropped without a completion");

    // A late completion cannot clear busy while held in reset
    AST_RESET_KEEPS_BUSY: assert property (
        conv_reset |-> q.busy)
        else $error("busy low while converter held in reset");

    AST_POWER_OFF_WRITE: assert property (
        q.wr_pend && q.wr_idx == acsr_pkg::IDX_CTRL0
        && hwdata[acsr_pkg::C0_OFF] |=> converter_power_off)
        else $error("power-off not set by write");

    // The converter must leave reset before a conversion starts
    AST_START_AFTER_RESET: assert property (
        conv_start |-> !conv_reset && $past(conv_reset))
        else $error("start pulse without a preceding reset");

    AST_CTRL1_ROUTE_WRITE: assert property (
        q.wr_pend && q.wr_idx == acsr_pkg::IDX_CTRL1
        |=> bandgap_route == $past(hwdata[acsr_pkg::C1_INTREF]))
        else $error("internal reference select not taken from write");

    AST_CTRL1_GAPS_ZERO: assert property (
        rd_req && !rd_stall && addr_ok && a_idx == acsr_pkg::IDX_CTRL1
        |=> hrdata[5] == 1'b0 && hrdata[3] == 1'b0)
        else $error("control 1 unused bits read nonzero");

    // A stalled read costs one cycle only, the write ahead has landed
    AST_STALL_ONE_CYCLE: assert property (
        !hreadyout |=> hreadyout)
        else $error("read stall longer than one cycle");

    COV_CONVERSION: cover property (
        $fell(q.start) ##[1:50] $fell(q.busy));
    COV_IRQ: cover property ($rose(irq));
    COV_READ_STALL: cover property (rd_stall);
    COV_INTREF: cover property ($rose(bandgap_route));
endmodule

// ### sim/tb_top.sv
// Self-checking bench for the converter control and status registers
module tb_top;
    timeunit 1ns;
    timeprecision 100ps;

    logic hclk;
    logic hresetn;
    logic hsel;
    logic [31:0] haddr;
    logic [1:0] htrans;
    logic hwrite;
    logic [31:0] hwdata;
    logic hreadyout;
    logic hresp;
    logic [31:0] hrdata;
    logic conv_done;
    logic [11:0] conv_data;
    logic conv_reset;
    logic conv_start;
    logic converter_power_off;
    logic bandgap_enable;
    logic reference_source_select;
    logic [2:0] conv_clock_div;
    logic [3:0] analog_input_sel;
    logic bandgap_route;
    logic irq;
    int n_mismatch = 0;
    int n_tests = 0;
    int cyc = 0;

    acsr_top i_dut (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
        .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
        .hrdata(hrdata), .conv_done(conv_done), .conv_data(conv_data),
        .conv_reset(conv_reset), .conv_start(conv_start),
        .converter_power_off(converter_power_off),
        .bandgap_enable(bandgap_enable),
        .reference_source_select(reference_source_select),
        .conv_clock_div(conv_clock_div),
        .analog_input_sel(analog_input_sel),
        .bandgap_route(bandgap_route), .irq(irq)
    );

    initial
    begin
        hclk = 1'b0;
        forever #2 hclk = ~hclk;
    end

    task automatic give_verdict();
        $display("checks %0d mismatches %0d", n_tests, n_mismatch);
        if (n_mismatch == 0 && n_tests > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    // Bounded run; a hung handshake lands here
    always @(posedge hclk)
    begin
        cyc <= cyc + 1;
        if (cyc == 20000)
        begin
            n_mismatch++;
            give_verdict();
        end
    end

    task automatic chk(input string what, input logic [31:0] seen,
                       input logic [31:0] exp);
        n_tests++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // One AHB-Lite single transfer; waits on hready in both phases
    // Ready and read data are sampled mid-cycle, clear of the edge race
    task automatic xfer(input logic wr, input logic [31:0] a,
                        input logic [31:0] wd, output logic [31:0] rd);
        logic ok;
        @(posedge hclk);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= a;
        hwrite <= wr;
        do
        begin
            @(negedge hclk);
            ok = hreadyout;
            @(posedge hclk);
        end
        while (ok !== 1'b1);
        htrans <= 2'h0;
        hwdata <= wd;
        do
        begin
            @(negedge hclk);
            ok = hreadyout;
            rd = hrdata;
            @(posedge hclk);
        end
        while (ok !== 1'b1);
    endtask

    task automatic wr(input logic [31:0] a, input logic [31:0] d);
        logic [31:0] x;
        xfer(1'b1, a, d, x);
    endtask

    task automatic rdchk(input string what, input logic [31:0] a,
                         input logic [31:0] exp);
        logic [31:0] x;
        xfer(1'b0, a, 32'h0000_0000, x);
        chk(what, x, exp);
    endtask

    // Lets registered outputs of the last edge settle
    task automatic settle();
        @(posedge hclk);
        @(negedge hclk);
    endtask

    task automatic done_pulse(input logic [11:0] v);
        @(posedge hclk);
        conv_done <= 1'b1;
        conv_data <= v;
        @(posedge hclk);
        conv_done <= 1'b0;
    endtask

    initial
    begin
        hresetn = 1'b0;
        hsel = 1'b0;
        haddr = 32'h0000_0000;
        htrans = 2'h0;
        hwrite = 1'b0;
        hwdata = 32'h0000_0000;
        conv_done = 1'b0;
        conv_data = 12'h000;
        repeat (16) @(posedge hclk);
        hresetn <= 1'b1;
        rdchk("ctrl0 reset", 32'h00, 32'h0000_0060);
        rdchk("ctrl1 reset", 32'h04, 32'h0000_0000);
        chk("power off", {31'h0, converter_power_off}, 32'h1);
        chk("input sel", {28'h0, analog_input_sel}, 32'h1);
        // Start rise with power-off also raises the second event
        wr(32'h00, 32'h0000_00ff);
        rdchk("ctrl0 all ones", 32'h00, 32'h0000_00f3);
        chk("conv reset", {31'h0, conv_reset}, 32'h1);
        chk("power off set", {31'h0, converter_power_off}, 32'h1);
        rdchk("status start", 32'h10, 32'h0000_0002);
        wr(32'h14, 32'h0000_0001);
        settle();
        chk("irq masked", {31'h0, irq}, 32'h0);
        wr(32'h14, 32'h0000_0003);
        settle();
        chk("irq set", {31'h0, irq}, 32'h1);
        wr(32'h10, 32'h0000_0002);
        settle();
        chk("irq cleared", {31'h0, irq}, 32'h0);
        for (int c = 0; c < 4; c++)
        begin
            wr(32'h00, 32'(c));
            settle();
            chk("input sel", {28'h0, analog_input_sel}, 32'h1 << c);
            chk("power on", {31'h0, converter_power_off}, 32'h0);
        end
        wr(32'h04, 32'h0000_00ff);
        rdchk("ctrl1", 32'h04, 32'h0000_00d7);
        settle();
        chk("ext inputs off", {28'h0, analog_input_sel}, 32'h0);
        chk("bandgap route", {31'h0, bandgap_route}, 32'h1);
        chk("bandgap en", {31'h0, bandgap_enable}, 32'h1);
        chk("ref source", {31'h0, reference_source_select}, 32'h1);
        chk("clock div", {29'h0, conv_clock_div}, 32'h7);
        wr(32'h04, 32'h0000_0000);
        settle();
        chk("ext back", {28'h0, analog_input_sel}, 32'h8);
        chk("ref source off", {31'h0, reference_source_select}, 32'h0);
        chk("clock div off", {29'h0, conv_clock_div}, 32'h0);
        for (int j = 0; j < 2; j++)
        begin
            wr(32'h00, 32'h80 | (j << 4));
            rdchk("busy on start", 32'h00, 32'hc0 | (j << 4));
            wr(32'h00, 32'(j << 4));
            @(negedge hclk);
            chk("conv start", {31'h0, conv_start}, 32'h1);
            chk("conv reset low", {31'h0, conv_reset}, 32'h0);
            @(negedge hclk);
            chk("conv start end", {31'h0, conv_start}, 32'h0);
            rdchk("still busy", 32'h00, 32'h40 | (j << 4));
            done_pulse(12'ha5c);
            rdchk("busy off", 32'h00, 32'(j << 4));
            rdchk("res hi", 32'h08, (j == 1) ? 32'h0a : 32'ha5);
            rdchk("res lo", 32'h0c, (j == 1) ? 32'h5c : 32'hc0);
            chk("irq done", {31'h0, irq}, 32'h1);
            wr(32'h10, 32'h0000_0001);
            settle();
            chk("irq done clr", {31'h0, irq}, 32'h0);
        end
        // Completion while idle must be ignored
        done_pulse(12'h123);
        rdchk("res kept", 32'h08, 32'h0000_000a);
        chk("irq idle done", {31'h0, irq}, 32'h0);
        rdchk("unmapped", 32'h18, 32'h0000_0000);
        chk("hresp", {31'h0, hresp}, 32'h0);
        // Software powers the converter down ahead of a sleep mode
        wr(32'h00, 32'h0000_0020);
        settle();
        chk("power off sleep", {31'h0, converter_power_off}, 32'h1);
        give_verdict();
    end
endmodule
